// *** rtl/rsfc_defs.svh ***
// Purpose: Constants for the regulator sequence and fault control block.
// Assumes: Included by its bare name from the channel and top design modules.
// Notes: Offsets are register indices; the bus byte address is four times the index.
//
// How it works
// - Fault always interrupts; field picks extra action.
// - Fault action code 11 shuts system down.
// - Startup slot: off, slots 1-14, or active.
// - Shutdown slot: 0000/1111 at off, else slot.
// - Hibernate behaviour: image voltage or disable output.
// - Hibernate trigger: register bit or low-power inputs.
// - Image code: 50mV steps low, 100mV high.
// - Switch mode bypasses regulation and voltage select; the code clears regulate but still drives volt_code from output_voltage.
// - Output float bit chooses discharge when disabled.
// - All four regulators off forces every discharge.
// - Voltage select applies only in regulator mode; the code drives volt_code from output_voltage in switch mode too.
// - Fields reset by state machine to build defaults.
`ifndef RSFC_DEFS_SVH
`define RSFC_DEFS_SVH

// ----------------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------------
`define RSFC_IDX_A_SLOTS 8'hcf
`define RSFC_IDX_A_HIB 8'hd0
`define RSFC_IDX_B_CTRL 8'hd1
`define RSFC_IDX_B_SLOTS 8'hd2
`define RSFC_IDX_A_CTRL 8'he0
`define RSFC_IDX_B_HIB 8'he1
`define RSFC_IDX_SWCTL 8'he2
`define RSFC_IDX_IRQ_STAT 8'he3
`define RSFC_IDX_IRQ_MASK 8'he4
`define RSFC_IDX_STATUS 8'he5

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define RSFC_F_FAULT_HI 15
`define RSFC_F_FAULT_LO 14
`define RSFC_F_START_HI 13
`define RSFC_F_START_LO 10
`define RSFC_F_SHUT_HI 9
`define RSFC_F_SHUT_LO 6
`define RSFC_F_HMODE_HI 13
`define RSFC_F_HMODE_LO 12
`define RSFC_F_HTRIG_HI 9
`define RSFC_F_HTRIG_LO 8
`define RSFC_F_SWI 14
`define RSFC_F_OPFLT 10
`define RSFC_F_VOLT_HI 4
`define RSFC_F_VOLT_LO 0

// ----------------------------------------------------------------------
// Reset values (build option defaults)
// ----------------------------------------------------------------------
`define RSFC_RST_A_SLOTS 16'h1400
`define RSFC_RST_A_HIB 16'h001c
`define RSFC_RST_B_CTRL 16'h001b
`define RSFC_RST_B_SLOTS 16'h1000
`define RSFC_RST_A_CTRL 16'h001b
`define RSFC_RST_B_HIB 16'h001c

// ----------------------------------------------------------------------
// Codes and timing
// ----------------------------------------------------------------------
`define RSFC_SLOT_OFF 4'h0
`define RSFC_SLOT_ALL 4'hf
`define RSFC_HMODE_IMAGE 2'h0
`define RSFC_HMODE_DISABLE 2'h1
`define RSFC_WAIT_CYCLES 1

`endif

// *** rtl/rsfc_pkg.sv ***
// Purpose: Types for the regulator sequence and fault control block.
// Assumes: Compiled before the design modules.
// Notes: Constants live in the defs header.
package rsfc_pkg;

   // Fault reaction chosen by the fault-action field.
   typedef enum logic [1:0] {
      RSFC_ACT_IGNORE,
      RSFC_ACT_REG,
      RSFC_ACT_SYS,
      RSFC_ACT_SYS_RSVD
   } rsfc_act_t;

   // One regulator's control fields.
   typedef struct packed {
      logic [1:0] fault_action;
      logic [3:0] startup_slot;
      logic [3:0] shutdown_slot;
      logic [1:0] hib_behaviour;
      logic [1:0] hib_trigger;
      logic [4:0] image_voltage;
      logic switch_mode;
      logic output_float;
      logic [4:0] output_voltage;
   } rsfc_cfg_t;

   // Sequencer view from the power state machine.
   typedef struct packed {
      logic [3:0] slot;
      logic slot_strobe;
      logic enter_active;
      logic enter_off;
      logic sw_hibernate;
      logic [2:0] low_power;
   } rsfc_seq_t;

   // Drive to one regulator.
   typedef struct packed {
      logic enable;
      logic regulate;
      logic discharge;
      logic [4:0] volt_code;
   } rsfc_drv_t;

   // Bus slave states.
   typedef enum {
      RSFC_BUS_IDLE,
      RSFC_BUS_ACK
   } rsfc_bus_st_t;

endpackage

// *** rtl/rsfc_channel.sv ***
// Purpose: One regulator channel: sequencing, hibernate, voltage and fault.
// Assumes: Slot strobes come from the power state machine.
// Notes: Instantiated once per regulator.
`timescale 1ns/1ps
`include "rsfc_defs.svh"

module rsfc_channel
(
   // Clock and reset.
   input wire logic i_clock,
   input wire logic i_rst_n,
   // Configuration and sequencer.
   input wire rsfc_pkg::rsfc_cfg_t i_cfg,
   input wire rsfc_pkg::rsfc_seq_t i_seq,
   input wire logic i_fault,
   input wire logic i_all_off,
   // Results.
   output rsfc_pkg::rsfc_drv_t o_drv,
   output logic o_fault_event,
   output logic o_sys_shutdown
);
   import rsfc_pkg::*;

   // Channel state kept as one packed struct.
   typedef struct packed {
      logic on;
      logic tripped;
      logic fault_d;
      rsfc_drv_t drv;
      logic fault_event;
      logic sys_shutdown;
   } rsfc_ch_state_t;

   rsfc_ch_state_t state;
   rsfc_ch_state_t next_state;
   logic hib_now;
   logic fault_rise;

   // ----------------------------------------------------------------------
   // Next-state logic.
   // ----------------------------------------------------------------------
   always_comb
   begin
      next_state = state;
      fault_rise = i_fault && !state.fault_d;
      next_state.fault_d = i_fault;
      // Hibernate source: register bit or one of three low-power inputs.
      case (i_cfg.hib_trigger)
         2'h0: hib_now = i_seq.sw_hibernate;
         2'h1: hib_now = i_seq.low_power[0];
         2'h2: hib_now = i_seq.low_power[1];
         default: hib_now = i_seq.low_power[2];
      endcase
      // Start-up: a slot match, or entry to active for the all code.
      if (i_cfg.startup_slot != `RSFC_SLOT_OFF)
      begin
         if (i_cfg.startup_slot == `RSFC_SLOT_ALL)
         begin
            if (i_seq.enter_active)
            begin
               next_state.on = 1'b1;
            end
         end
         else if (i_seq.slot_strobe && i_seq.slot == i_cfg.startup_slot)
         begin
            next_state.on = 1'b1;
         end
      end
      // Shut-down: 0000 and 1111 act on entry to off, others on their slot.
      if (i_cfg.shutdown_slot == `RSFC_SLOT_OFF
          || i_cfg.shutdown_slot == `RSFC_SLOT_ALL)
      begin
         if (i_seq.enter_off)
         begin
            next_state.on = 1'b0;
            next_state.tripped = 1'b0;
         end
      end
      else if (i_seq.slot_strobe && i_seq.slot == i_cfg.shutdown_slot)
      begin
         next_state.on = 1'b0;
      end
      // A new fault always raises the event; the action field adds more.
      next_state.fault_event = fault_rise;
      next_state.sys_shutdown = 1'b0;
      if (fault_rise)
      begin
         case (rsfc_act_t'(i_cfg.fault_action))
            RSFC_ACT_IGNORE: next_state.tripped = state.tripped;
            RSFC_ACT_REG: next_state.tripped = 1'b1;
            RSFC_ACT_SYS: next_state.sys_shutdown = 1'b1;
            RSFC_ACT_SYS_RSVD: next_state.sys_shutdown = 1'b1;
            default: next_state.sys_shutdown = 1'b1;
         endcase
      end
      // Output drive, registered so every output leaves a flip-flop.
      next_state.drv.enable = state.on && !state.tripped
         && !(hib_now && i_cfg.hib_behaviour == `RSFC_HMODE_DISABLE);
      next_state.drv.regulate = !i_cfg.switch_mode;
      // Image voltage when hibernating in image mode, otherwise the select code; the code map
      // itself lives in the analogue trim, shared by both fields.
      if (hib_now && i_cfg.hib_behaviour == `RSFC_HMODE_IMAGE)
      begin
         next_state.drv.volt_code = i_cfg.image_voltage;
      end
      else
      begin
         next_state.drv.volt_code = i_cfg.output_voltage;
      end
      // Discharge when disabled unless floating, and always when all are off.
      next_state.drv.discharge = !next_state.drv.enable
         && (!i_cfg.output_float || i_all_off);
   end

   // ----------------------------------------------------------------------
   // State register; the state machine reset returns it to off.
   // ----------------------------------------------------------------------
   always_ff @(posedge i_clock)
   begin
      if (!i_rst_n)
      begin
         state <= '0;
      end
      else
      begin
         state <= next_state;
      end
   end

   assign o_drv = state.drv;
   assign o_fault_event = state.fault_event;
   assign o_sys_shutdown = state.sys_shutdown;
endmodule

// *** rtl/rsfc_top.sv ***
// Purpose: Register file and Avalon-MM slave for two regulator channels.
// Assumes: Sequencer strobes and fault levels are synchronous to i_clock.
// Notes: Registers answer one cycle after a request; unmapped reads are zero.
//
// The Avalon-MM register port was chosen for this implementation.
`timescale 1ns/1ps
`include "rsfc_defs.svh"

module rsfc_top
(
   // Clock and reset.
   input wire logic i_clock,
   input wire logic i_rst_n,
   // Avalon-MM slave.
   input wire logic [9:0] i_address,
   input wire logic i_read,
   input wire logic i_write,
   input wire logic [31:0] i_writedata,
   input wire logic [3:0] i_byteenable,
   output logic [31:0] o_readdata,
   output logic o_waitrequest,
   // Power state machine.
   input wire rsfc_pkg::rsfc_seq_t i_seq,
   input wire logic i_sm_reset,
   input wire logic [1:0] i_other_enabled,
   input wire logic [1:0] i_fault,
   // Regulator drive.
   output rsfc_pkg::rsfc_drv_t o_drv_a,
   output rsfc_pkg::rsfc_drv_t o_drv_b,
   output logic o_sys_shutdown,
   output logic o_irq
);
   import rsfc_pkg::*;

   // ----------------------------------------------------------------------
   // Whole block state.
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic [15:0] a_slots;
      logic [15:0] a_hib;
      logic [15:0] a_ctrl;
      logic [15:0] b_slots;
      logic [15:0] b_hib;
      logic [15:0] b_ctrl;
      logic sw_hib;
      logic [1:0] irq_stat;
      logic [1:0] irq_mask;
      logic [31:0] rdata;
      logic wait_n;
      rsfc_bus_st_t bus;
      logic irq;
      logic sys_down;
   } rsfc_top_state_t;

   rsfc_top_state_t state;
   rsfc_top_state_t next_state;
   rsfc_cfg_t cfg_a;
   rsfc_cfg_t cfg_b;
   rsfc_seq_t seq;
   rsfc_drv_t drv_a;
   rsfc_drv_t drv_b;
   logic [1:0] fault_ev;
   logic [1:0] sys_req;
   logic all_off;
   logic [7:0] idx;
   logic [15:0] wmask;
   logic [15:0] wdat;

   // Map a channel's three registers (slots, hib, ctrl) into its fields.
   function automatic rsfc_cfg_t unpack_cfg(input logic [15:0] slots,
      input logic [15:0] hib, input logic [15:0] ctrl);
      rsfc_cfg_t c;
      c.fault_action = slots[`RSFC_F_FAULT_HI:`RSFC_F_FAULT_LO];
      c.startup_slot = slots[`RSFC_F_START_HI:`RSFC_F_START_LO];
      c.shutdown_slot = slots[`RSFC_F_SHUT_HI:`RSFC_F_SHUT_LO];
      c.hib_behaviour = hib[`RSFC_F_HMODE_HI:`RSFC_F_HMODE_LO];
      c.hib_trigger = hib[`RSFC_F_HTRIG_HI:`RSFC_F_HTRIG_LO];
      c.image_voltage = hib[`RSFC_F_VOLT_HI:`RSFC_F_VOLT_LO];
      c.switch_mode = ctrl[`RSFC_F_SWI];
      c.output_float = ctrl[`RSFC_F_OPFLT];
      c.output_voltage = ctrl[`RSFC_F_VOLT_HI:`RSFC_F_VOLT_LO];
      return c;
   endfunction

   // Keep only the documented bits of a written value.
   function automatic logic [15:0] merge(input logic [15:0] old_v,
      input logic [15:0] new_v, input logic [15:0] keep);
      return (old_v & ~keep) | (new_v & keep);
   endfunction

   // ----------------------------------------------------------------------
   // Channels: two identical instances, coupled only through all_off.
   // ----------------------------------------------------------------------
   always_comb
   begin
      cfg_a = unpack_cfg(state.a_slots, state.a_hib, state.a_ctrl);
      cfg_b = unpack_cfg(state.b_slots, state.b_hib, state.b_ctrl);
      seq = i_seq;
      seq.sw_hibernate = state.sw_hib;
      // All four off: the two outside regulators and both of ours.
      all_off = (i_other_enabled == 2'h0)
         && !drv_a.enable && !drv_b.enable;
   end

   rsfc_channel u_chan_a
   (
      .i_clock(i_clock),
      .i_rst_n(i_rst_n && !i_sm_reset),
      .i_cfg(cfg_a),
      .i_seq(seq),
      .i_fault(i_fault[0]),
      .i_all_off(all_off),
      .o_drv(drv_a),
      .o_fault_event(fault_ev[0]),
      .o_sys_shutdown(sys_req[0])
   );

   rsfc_channel u_chan_b
   (
      .i_clock(i_clock),
      .i_rst_n(i_rst_n && !i_sm_reset),
      .i_cfg(cfg_b),
      .i_seq(seq),
      .i_fault(i_fault[1]),
      .i_all_off(all_off),
      .o_drv(drv_b),
      .o_fault_event(fault_ev[1]),
      .o_sys_shutdown(sys_req[1])
   );

   // ----------------------------------------------------------------------
   // Register file, interrupt and bus slave.
   // ----------------------------------------------------------------------
   always_comb
   begin
      next_state = state;
      idx = i_address[9:2];
      wmask = {{8{i_byteenable[1]}}, {8{i_byteenable[0]}}};
      wdat = i_writedata[15:0];
      next_state.wait_n = 1'b0;
      next_state.bus = RSFC_BUS_IDLE;
      // A request is answered in the cycle after it is seen.
      if ((i_read || i_write) && state.bus == RSFC_BUS_IDLE)
      begin
         next_state.bus = RSFC_BUS_ACK;
         next_state.wait_n = 1'b1;
         next_state.rdata = 32'h0;
         if (i_write)
         begin
            case (idx)
               `RSFC_IDX_A_SLOTS: next_state.a_slots =
                  merge(state.a_slots, wdat, wmask & 16'hffc0);
               `RSFC_IDX_A_HIB: next_state.a_hib =
                  merge(state.a_hib, wdat, wmask & 16'h331f);
               `RSFC_IDX_A_CTRL: next_state.a_ctrl =
                  merge(state.a_ctrl, wdat, wmask & 16'h441f);
               `RSFC_IDX_B_SLOTS: next_state.b_slots =
                  merge(state.b_slots, wdat, wmask & 16'hffc0);
               `RSFC_IDX_B_HIB: next_state.b_hib =
                  merge(state.b_hib, wdat, wmask & 16'h331f);
               `RSFC_IDX_B_CTRL: next_state.b_ctrl =
                  merge(state.b_ctrl, wdat, wmask & 16'h441f);
               `RSFC_IDX_SWCTL: next_state.sw_hib =
                  i_byteenable[0] ? wdat[0] : state.sw_hib;
               `RSFC_IDX_IRQ_MASK: next_state.irq_mask =
                  i_byteenable[0] ? wdat[1:0] : state.irq_mask;
               default: next_state.wait_n = 1'b1;
            endcase
         end
         else
         begin
            case (idx)
               `RSFC_IDX_A_SLOTS: next_state.rdata = {16'h0, state.a_slots};
               `RSFC_IDX_A_HIB: next_state.rdata = {16'h0, state.a_hib};
               `RSFC_IDX_A_CTRL: next_state.rdata = {16'h0, state.a_ctrl};
               `RSFC_IDX_B_SLOTS: next_state.rdata = {16'h0, state.b_slots};
               `RSFC_IDX_B_HIB: next_state.rdata = {16'h0, state.b_hib};
               `RSFC_IDX_B_CTRL: next_state.rdata = {16'h0, state.b_ctrl};
               `RSFC_IDX_SWCTL: next_state.rdata = {31'h0, state.sw_hib};
               `RSFC_IDX_IRQ_STAT: next_state.rdata = {30'h0, state.irq_stat};
               `RSFC_IDX_IRQ_MASK: next_state.rdata = {30'h0, state.irq_mask};
               `RSFC_IDX_STATUS: next_state.rdata =
                  {26'h0, drv_b.discharge, drv_b.enable, drv_a.discharge,
                   drv_a.enable, 2'h0};
               default: next_state.rdata = 32'h0;
            endcase
         end
      end
      // Write one to clear; a fault in the same cycle wins over the clear.
      if (i_write && state.bus == RSFC_BUS_IDLE && idx == `RSFC_IDX_IRQ_STAT
          && i_byteenable[0])
      begin
         next_state.irq_stat = state.irq_stat & ~wdat[1:0];
      end
      next_state.irq_stat = next_state.irq_stat | fault_ev;
      next_state.irq = |(next_state.irq_stat & next_state.irq_mask);
      next_state.sys_down = |sys_req;
   end

   // ----------------------------------------------------------------------
   // State register. The power state machine reset restores the build
   // defaults, not only power-on; the interrupt state survives it.
   // ----------------------------------------------------------------------
   always_ff @(posedge i_clock)
   begin
      if (!i_rst_n)
      begin
         state <= '0;
         state.a_slots <= `RSFC_RST_A_SLOTS;
         state.a_hib <= `RSFC_RST_A_HIB;
         state.a_ctrl <= `RSFC_RST_A_CTRL;
         state.b_slots <= `RSFC_RST_B_SLOTS;
         state.b_hib <= `RSFC_RST_B_HIB;
         state.b_ctrl <= `RSFC_RST_B_CTRL;
         state.bus <= RSFC_BUS_IDLE;
      end
      else if (i_sm_reset)
      begin
         state <= next_state;
         state.a_slots <= `RSFC_RST_A_SLOTS;
         state.a_hib <= `RSFC_RST_A_HIB;
         state.a_ctrl <= `RSFC_RST_A_CTRL;
         state.b_slots <= `RSFC_RST_B_SLOTS;
         state.b_hib <= `RSFC_RST_B_HIB;
         state.b_ctrl <= `RSFC_RST_B_CTRL;
         state.sw_hib <= 1'b0;
      end
      else
      begin
         state <= next_state;
      end
   end

   // Outputs straight from flip-flops.
   assign o_readdata = state.rdata;
   assign o_waitrequest = !state.wait_n;
   assign o_drv_a = drv_a;
   assign o_drv_b = drv_b;
   assign o_sys_shutdown = state.sys_down;
   assign o_irq = state.irq;
endmodule

// *** verif/rsfc_assertions.sv ***
// Purpose: Port-level checker for the regulator sequence and fault block.
// Assumes: One clock domain; i_rst_n is synchronous and active low.
// Notes: Sees only top ports.
`timescale 1ns/1ps
module rsfc_assertions
(
   // Clock and reset.
   input wire logic i_clock,
   input wire logic i_rst_n,
   // Bus and events.
   input wire logic i_read,
   input wire logic i_write,
   input wire logic [1:0] i_fault,
   input wire logic [1:0] i_other_enabled,
   input wire logic [31:0] o_readdata,
   input wire logic o_waitrequest,
   // Results.
   input wire rsfc_pkg::rsfc_drv_t o_drv_a,
   input wire rsfc_pkg::rsfc_drv_t o_drv_b,
   input wire logic o_sys_shutdown,
   input wire logic o_irq
);
   import rsfc_pkg::*;
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_rst_n);
   // ------------------------------------------------------------
   // Helper history
   // ------------------------------------------------------------
   logic [1:0] fault_d; // Last fault levels, for edge detection.
   logic [4:0] evt_h; // Recent writes or fault rises.
   logic [4:0] wr_h; // Recent writes only.
   // Keep a short window so an irq edge can be traced to its cause.
   always_ff @(posedge i_clock)
   begin
      if (!i_rst_n)
      begin
         fault_d <= i_fault;
         evt_h <= 5'h00;
         wr_h <= 5'h00;
      end
      else
      begin
         fault_d <= i_fault;
         evt_h <= {evt_h[3:0], i_write | (|(i_fault & ~fault_d))};
         wr_h <= {wr_h[3:0], i_write};
      end
   end
   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   property p_rst;
      @(posedge i_clock) disable iff (1'b0)
      !i_rst_n |=> o_waitrequest && !o_irq && o_drv_a == '0 && o_drv_b == '0;
   endproperty
   a_rst: assert property (p_rst) else $error("reset outputs wrong");
   property p_answer;
      $rose(i_read || i_write) |=> !o_waitrequest;
   endproperty
   a_answer: assert property (p_answer) else $error("bus answer late");
   property p_wait_one;
      !o_waitrequest |=> o_waitrequest;
   endproperty
   a_wait_one: assert property (p_wait_one) else $error("waitrequest low too long");
   property p_rd_hi;
      !o_waitrequest |-> o_readdata[31:16] == 16'h0000;
   endproperty
   a_rd_hi: assert property (p_rd_hi) else $error("upper read data not zero");
   property p_sys_pulse;
      o_sys_shutdown |=> !o_sys_shutdown;
   endproperty
   a_sys_pulse: assert property (p_sys_pulse) else $error("shutdown pulse too long");
   property p_dis_off;
      (o_drv_a.discharge |-> !o_drv_a.enable) and (o_drv_b.discharge |-> !o_drv_b.enable);
   endproperty
   a_dis_off: assert property (p_dis_off) else $error("discharge while enabled");
   property p_all_off;
      (i_other_enabled == 2'h0 && !o_drv_a.enable && !o_drv_b.enable) [*2] |=>
         (o_drv_a.enable || o_drv_b.enable || (o_drv_a.discharge && o_drv_b.discharge));
   endproperty
   a_all_off: assert property (p_all_off) else $error("all off without discharge");
   property p_irq_rise;
      $rose(o_irq) |-> evt_h != 5'h00;
   endproperty
   a_irq_rise: assert property (p_irq_rise) else $error("irq rose without cause");
   property p_irq_fall;
      $fell(o_irq) |-> wr_h != 5'h00;
   endproperty
   a_irq_fall: assert property (p_irq_fall) else $error("irq fell without write");
   c_sys: cover property (o_sys_shutdown);
   c_irq: cover property ($rose(o_irq));
   c_all: cover property (o_drv_a.discharge && o_drv_b.discharge);
endmodule

bind rsfc_top rsfc_assertions u_rsfc_assertions (.i_clock(i_clock), .i_rst_n(i_rst_n),
   .i_read(i_read), .i_write(i_write), .i_fault(i_fault), .i_other_enabled(i_other_enabled),
   .o_readdata(o_readdata), .o_waitrequest(o_waitrequest), .o_drv_a(o_drv_a),
   .o_drv_b(o_drv_b), .o_sys_shutdown(o_sys_shutdown), .o_irq(o_irq));

// *** verif/rsfc_top_tb_top.sv ***
// Purpose: Self-checking bench for the regulator sequence and fault block.
// Assumes: Slave answers one cycle after a request is taken.
// Notes: Outputs are read at the falling edge; bus read data at the rising edge.
`timescale 1ns/1ps
module rsfc_top_tb_top;
   import rsfc_pkg::*;
   // ------------------------------------------------------------
   // Stimulus and results
   // ------------------------------------------------------------
   logic i_clock = 1'b0;
   logic i_rst_n = 1'b0;
   logic i_read = 1'b0;
   logic i_write = 1'b0;
   logic i_sm_reset = 1'b0;
   logic [9:0] i_address = 10'h000;
   logic [31:0] i_writedata = 32'h0;
   logic [3:0] i_byteenable = 4'h0;
   logic [1:0] i_other_enabled = 2'h3; // Other regulators on.
   logic [1:0] i_fault = 2'h0;
   rsfc_seq_t i_seq = '0;
   logic [31:0] o_readdata;
   logic o_waitrequest, o_sys_shutdown, o_irq;
   rsfc_drv_t o_drv_a, o_drv_b;
   int miscompares = 0;
   int num_checks = 0;
   logic [15:0] rd; // Last read data.
   logic sd; // Shutdown pulse seen.
   // Free-running 25 MHz clock.
   always #20 i_clock = ~i_clock;
   rsfc_top u_rsfc_top (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_address(i_address),
      .i_read(i_read), .i_write(i_write), .i_writedata(i_writedata),
      .i_byteenable(i_byteenable), .o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
      .i_seq(i_seq), .i_sm_reset(i_sm_reset), .i_other_enabled(i_other_enabled),
      .i_fault(i_fault), .o_drv_a(o_drv_a), .o_drv_b(o_drv_b),
      .o_sys_shutdown(o_sys_shutdown), .o_irq(o_irq));
   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task give_verdict();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task chk(input string nm, input logic [15:0] s, input logic [15:0] e);
      num_checks++;
      if (s !== e)
      begin
         miscompares++;
         $display("BAD %s exp %h saw %h", nm, e, s);
      end
   endtask
   // Let n edges pass, then settle on the falling edge.
   task tick(input int n);
      repeat (n) @(posedge i_clock);
      @(negedge i_clock);
   endtask
   // One Avalon access; a bounded wait ends a dead run.
   task bus(input logic wr, input logic [7:0] idx, input logic [15:0] d);
      int n;
      n = 0;
      @(posedge i_clock);
      i_address <= {idx, 2'b00};
      i_write <= wr;
      i_read <= !wr;
      i_writedata <= {16'h0000, d};
      i_byteenable <= 4'h3;
      do
      begin
         @(posedge i_clock);
         n++;
      end
      while (o_waitrequest !== 1'b0 && n < 20);
      rd = o_readdata[15:0];
      i_write <= 1'b0;
      i_read <= 1'b0;
      if (n >= 20)
      begin
         miscompares++;
         give_verdict();
      end
   endtask
   task wr16(input logic [7:0] idx, input logic [15:0] d);
      bus(1'b1, idx, d);
   endtask
   // Kind 0 is a slot strobe, 1 entry to active, 2 entry to off.
   task seq(input int kind, input logic [3:0] s);
      @(posedge i_clock);
      i_seq.slot <= s;
      i_seq.slot_strobe <= (kind == 0);
      i_seq.enter_active <= (kind == 1);
      i_seq.enter_off <= (kind == 2);
      @(posedge i_clock);
      i_seq.slot_strobe <= 1'b0;
      i_seq.enter_active <= 1'b0;
      i_seq.enter_off <= 1'b0;
      tick(2);
   endtask
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task t_defaults();
      bus(0, 8'hcf, 0); chk("a_slots", rd, 16'h1400);
      bus(0, 8'hd0, 0); chk("a_hib", rd, 16'h001c);
      bus(0, 8'hd1, 0); chk("b_ctrl", rd, 16'h001b);
      bus(0, 8'hd2, 0); chk("b_slots", rd, 16'h1000);
      bus(0, 8'h10, 0); chk("unmapped", rd, 16'h0000);
   endtask
   task t_slots();
      wr16(8'hcf, 16'h3c00); seq(1, 0); chk("en active", o_drv_a.enable, 1);
      seq(2, 0); chk("off 0000", o_drv_a.enable, 0);
      wr16(8'hcf, 16'h15c0); seq(0, 4); chk("slot 4", o_drv_a.enable, 0);
      seq(0, 5); chk("slot 5", o_drv_a.enable, 1);
      seq(0, 7); chk("shut 7", o_drv_a.enable, 0);
      wr16(8'hcf, 16'h3fc0); seq(1, 0); seq(2, 0); chk("off 1111", o_drv_a.enable, 0);
      wr16(8'hcf, 16'h0000); seq(1, 0); chk("start 0000", o_drv_a.enable, 0);
      wr16(8'hd2, 16'h3800); seq(0, 14); chk("b slot 14", o_drv_b.enable, 1);
      seq(2, 0);
   endtask
   // Raise a fault on channel ch under action act and judge the reaction.
   task t_fault(input int ch, input logic [1:0] act);
      wr16(ch ? 8'hd2 : 8'hcf, {act, 14'h3c00});
      seq(1, 0);
      sd = 1'b0;
      @(posedge i_clock);
      i_fault[ch] <= 1'b1;
      repeat (6)
      begin
         @(negedge i_clock);
         sd = sd | o_sys_shutdown;
      end
      chk("sys shutdown", sd, act[1]);
      chk("irq set", o_irq, 1);
      if (!act[1])
         chk("en after fault", ch ? o_drv_b.enable : o_drv_a.enable, !act[0]);
      @(posedge i_clock) i_fault[ch] <= 1'b0;
      wr16(8'he3, 16'h0003);
      tick(2);
      chk("irq cleared", o_irq, 0);
      seq(2, 0);
   endtask
   task t_mask();
      wr16(8'he4, 16'h0000);
      @(posedge i_clock);
      i_fault[0] <= 1'b1;
      tick(4);
      chk("irq masked", o_irq, 0);
      wr16(8'he4, 16'h0003);
      tick(2);
      chk("irq unmasked", o_irq, 1);
      @(posedge i_clock) i_fault[0] <= 1'b0;
      wr16(8'he3, 16'h0001);
      tick(2);
      chk("irq clear", o_irq, 0);
   endtask
   task t_voltage();
      wr16(8'hd1, 16'h0005); wr16(8'hd2, 16'h3c00); seq(1, 0);
      chk("b volt", o_drv_b.volt_code, 16'h0005);
      chk("b regulate", o_drv_b.regulate, 1);
      wr16(8'hd1, 16'h4005); tick(2); chk("b switch", o_drv_b.regulate, 0);
      seq(2, 0);
      wr16(8'hd1, 16'h0405); tick(2); chk("float", o_drv_b.discharge, 0);
      wr16(8'hd1, 16'h0005); tick(2); chk("discharge", o_drv_b.discharge, 1);
      wr16(8'hd1, 16'h0405); wr16(8'he0, 16'h041b);
      i_other_enabled <= 2'h0;
      tick(3);
      chk("all off b", o_drv_b.discharge, 1);
      chk("all off a", o_drv_a.discharge, 1);
      @(posedge i_clock) i_other_enabled <= 2'h3;
   endtask
   // Low-power inputs or the register bit put channel a into hibernate.
   task t_hib();
      wr16(8'he0, 16'h0003); wr16(8'hd0, 16'h010f); wr16(8'hcf, 16'h3c00); seq(1, 0);
      @(posedge i_clock) i_seq.low_power <= 3'h1;
      tick(2);
      chk("image volt", o_drv_a.volt_code, 16'h000f);
      chk("image en", o_drv_a.enable, 1);
      @(posedge i_clock) i_seq.low_power <= 3'h0;
      tick(2);
      chk("normal volt", o_drv_a.volt_code, 16'h0003);
      for (int t = 0; t < 4; t++)
      begin
         wr16(8'hd0, 16'h100f | (t << 8));
         if (t == 0) wr16(8'he2, 16'h0001); else i_seq.low_power <= 3'h1 << (t - 1);
         tick(2);
         chk("hib off", o_drv_a.enable, 0);
         if (t == 0) wr16(8'he2, 16'h0000); else @(posedge i_clock) i_seq.low_power <= 3'h0;
         tick(2);
         chk("hib exit", o_drv_a.enable, 1);
      end
      seq(2, 0);
   endtask
   task t_sm_reset();
      wr16(8'hcf, 16'hffc0);
      @(posedge i_clock);
      i_sm_reset <= 1'b1;
      @(posedge i_clock);
      i_sm_reset <= 1'b0;
      tick(1);
      bus(0, 8'hcf, 0); chk("sm reset", rd, 16'h1400);
   endtask
   // Main sequence: reset held six cycles, then each scenario in turn.
   initial
   begin
      repeat (6) @(posedge i_clock);
      i_rst_n <= 1'b1;
      tick(1);
      t_defaults();
      t_slots();
      wr16(8'he4, 16'h0003);
      for (int a = 0; a < 4; a++) t_fault(0, a);
      t_fault(1, 2'h2);
      t_fault(1, 2'h1);
      t_mask();
      t_voltage();
      t_hib();
      t_sm_reset();
      give_verdict();
   end
endmodule
